/* design/pin_mux_pkg.sv */
package pin_mux_pkg;

  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] SELECT_OFS  = 8'h00;
  localparam logic [7:0] MAP_OFS     = 8'h04;
  localparam logic [7:0] PROTECT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h0c;

  // pins 4..8 are handled here; pin index 0 means pin 4
  localparam int NUM_PINS  = 5;
  localparam int FIRST_PIN = 4;
  localparam int FIELD_W   = 2;

  // field positions inside the select register
  localparam int PIN4_LSB = 8;
  localparam int PIN5_LSB = 10;
  localparam int PIN6_LSB = 12;
  localparam int PIN7_LSB = 14;
  localparam int PIN8_LSB = 16;

  // function codes
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_PWM  = 2'h1;
  localparam logic [1:0] CODE_FN2  = 2'h2;
  localparam logic [1:0] CODE_FN3  = 2'h3;

  // mapping select value that picks the alternate pwm assignment
  localparam logic [1:0] MAP_ALT = 2'h3;

  // reset values and implemented-bit masks
  localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] SELECT_MASK  = 32'h0003_ff00;
  localparam logic [1:0]  MAP_RESET    = 2'h0;
  localparam logic        PROT_RESET   = 1'b0;

  // status register layout
  localparam int STAT_RSVD_LSB = 0;
  localparam int STAT_BLOCKED  = 8;

  // one pin or peripheral drive: data and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } drive_t;

  // the register port as one carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

/* design/port_a_pin_function_mux.sv */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps

// How it works
// RL1: pin 8 field selects gpio, can-b, adc start
// RL2: pin 8 code 01 pwm5a, alternate pwm9a
// RL3: pin 7 field selects gpio, spi-d enable, capture2
// RL4: pin 7 code 01 pwm4b, alternate pwm8a
// RL5: pin 6 field selects gpio, sync in, out
// RL6: pin 6 code 01 pwm4a, alternate pwm7a
// RL7: pin 5 field selects gpio, spi-d clock, capture1
// RL8: pin 5 code 01 pwm3b, alternate pwm6a
// RL9: pin 4 gpio or pwm; 10/11 reserved
// RL10: reserved codes undefined; software must avoid them
// RL11: absent peripheral code behaves as reserved code
// RL12: select writes need protected write enable set
// RL13: new routing next cycle, other pins untouched
module port_a_pin_function_mux #(
  parameter int HAS_ALT_MAP = 1,
  parameter int HAS_CAN_B   = 1,
  parameter int HAS_SPI_D   = 1,
  parameter int HAS_CAP1    = 1,
  parameter int HAS_CAP2    = 1,
  parameter int HAS_PWM3    = 1,
  parameter int HAS_PWM4    = 1,
  parameter int HAS_PWM5    = 1,
  parameter int HAS_PWM6    = 1,
  parameter int HAS_PWM7    = 1,
  parameter int HAS_PWM8    = 1,
  parameter int HAS_PWM9    = 1
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire pin_mux_pkg::reg_req_t    req,
  output logic [31:0]                   rd_data,
  input  wire logic [4:0]               pin_in,
  output logic [4:0]                    pin_out,
  output logic [4:0]                    pin_oe_n,
  input  wire pin_mux_pkg::drive_t [4:0] gpio_drive,
  output logic [4:0]                    gpio_in,
  input  wire logic                     pwm3_channel_a,
  input  wire logic                     pwm3_channel_b,
  input  wire logic                     pwm4_channel_a,
  input  wire logic                     pwm4_channel_b,
  input  wire logic                     pwm5_channel_a,
  input  wire logic                     pwm6_channel_a,
  input  wire logic                     pwm7_channel_a,
  input  wire logic                     pwm8_channel_a,
  input  wire logic                     pwm9_channel_a,
  input  wire logic                     can_b_transmit,
  input  wire logic                     adc_conversion_start_a_out,
  input  wire logic                     pwm_sync_output,
  input  wire pin_mux_pkg::drive_t      spi_d_transmit_enable,
  input  wire pin_mux_pkg::drive_t      spi_d_clock,
  input  wire pin_mux_pkg::drive_t      capture_unit_1_signal,
  input  wire pin_mux_pkg::drive_t      capture_unit_2_signal,
  output logic                          pwm_sync_input,
  output logic                          spi_d_transmit_enable_in,
  output logic                          spi_d_clock_in,
  output logic                          capture_unit_1_in,
  output logic                          capture_unit_2_in
);

  // variant flags must be plain booleans
  if (HAS_ALT_MAP > 1 || HAS_CAN_B > 1 || HAS_SPI_D > 1 || HAS_CAP1 > 1 ||
      HAS_CAP2 > 1 || HAS_PWM3 > 1 || HAS_PWM4 > 1 || HAS_PWM5 > 1 ||
      HAS_PWM6 > 1 || HAS_PWM7 > 1 || HAS_PWM8 > 1 || HAS_PWM9 > 1 ||
      HAS_ALT_MAP < 0 || HAS_CAN_B < 0 || HAS_SPI_D < 0 || HAS_CAP1 < 0 ||
      HAS_CAP2 < 0 || HAS_PWM3 < 0 || HAS_PWM4 < 0 || HAS_PWM5 < 0 ||
      HAS_PWM6 < 0 || HAS_PWM7 < 0 || HAS_PWM8 < 0 || HAS_PWM9 < 0) begin
    $error("variant flags must be 0 or 1");
  end

  localparam pin_mux_pkg::drive_t RELEASED = '{out: 1'b0, oe_n: 1'b1};

  logic [31:0]  sel_q;
  logic [1:0]   map_q;
  logic         prot_q;
  logic         blocked_q;
  logic [31:0]  rd_data_q;
  logic [4:0]   pin_out_q;
  logic [4:0]   pin_oe_n_q;
  logic [4:0]   gpio_in_q;
  logic [4:0]   rsvd;
  logic         alt;
  logic         sync_in_q;
  logic         spi_te_in_q;
  logic         spi_clk_in_q;
  logic         cap1_in_q;
  logic         cap2_in_q;
  logic         sel_wr;
  logic         sel_blocked;
  pin_mux_pkg::drive_t [4:0] drive_d;

  // two-bit field of one pin, index 0 is pin 4
  function automatic logic [1:0] field(input logic [31:0] sel,
                                       input int          idx);
    field = sel[pin_mux_pkg::PIN4_LSB + pin_mux_pkg::FIELD_W * idx +: 2];
  endfunction

  // a code is usable only if its peripheral exists on this variant
  function automatic logic code_ok(input int idx, input logic [1:0] code,
                                   input logic alt_map);
    logic ok;
    ok = 1'b0;
    case (code)
      pin_mux_pkg::CODE_GPIO: ok = 1'b1;
      pin_mux_pkg::CODE_PWM: begin
        case (idx)
          0: ok = alt_map ? HAS_PWM5 != 0 : HAS_PWM3 != 0;
          1: ok = alt_map ? HAS_PWM6 != 0 : HAS_PWM3 != 0;
          2: ok = alt_map ? HAS_PWM7 != 0 : HAS_PWM4 != 0;
          3: ok = alt_map ? HAS_PWM8 != 0 : HAS_PWM4 != 0;
          default: ok = alt_map ? HAS_PWM9 != 0 : HAS_PWM5 != 0;
        endcase
      end
      pin_mux_pkg::CODE_FN2: begin
        case (idx)
          0: ok = 1'b0;
          1: ok = HAS_SPI_D != 0;
          2: ok = 1'b1;
          3: ok = HAS_SPI_D != 0;
          default: ok = HAS_CAN_B != 0;
        endcase
      end
      default: begin
        case (idx)
          0: ok = 1'b0;
          1: ok = HAS_CAP1 != 0;
          2: ok = 1'b1;
          3: ok = HAS_CAP2 != 0;
          default: ok = 1'b1;
        endcase
      end
    endcase
    code_ok = ok;
  endfunction

  // alternate pwm mapping applies only where the variant has it
  assign alt = (HAS_ALT_MAP != 0) && (map_q == pin_mux_pkg::MAP_ALT);

  assign sel_wr = req.wr && req.addr == pin_mux_pkg::SELECT_OFS;
  assign sel_blocked = sel_wr && !prot_q;

  // pin function select; only fields for pins 8..4 are held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q <= pin_mux_pkg::SELECT_RESET; // [RL1] [RL3] [RL5] [RL7] [RL9]
    end else if (sel_wr && prot_q) begin // [RL12]
      sel_q <= req.wdata & pin_mux_pkg::SELECT_MASK; // [RL13]
    end
  end

  // pwm mapping select, guarded like the select register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      map_q <= pin_mux_pkg::MAP_RESET;
    end else if (req.wr && req.addr == pin_mux_pkg::MAP_OFS && prot_q) begin
      map_q <= req.wdata[1:0];
    end
  end

  // protected write enable, freely writable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prot_q <= pin_mux_pkg::PROT_RESET;
    end else if (req.wr && req.addr == pin_mux_pkg::PROTECT_OFS) begin
      prot_q <= req.wdata[0];
    end
  end

  // sticky flag for a refused select write; a new refusal beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blocked_q <= 1'b0;
    end else if (sel_blocked) begin
      blocked_q <= 1'b1; // [RL12]
    end else if (req.wr && req.addr == pin_mux_pkg::STATUS_OFS &&
                 req.wdata[pin_mux_pkg::STAT_BLOCKED]) begin
      blocked_q <= 1'b0;
    end
  end

  // per-pin reserved indication, shown in status
  always_comb begin
    for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
      rsvd[i] = !code_ok(i, field(sel_q, i), alt); // [RL10] [RL11]
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.addr)
        pin_mux_pkg::SELECT_OFS:  rd_data_q <= sel_q;
        pin_mux_pkg::MAP_OFS:     rd_data_q <= {30'h0000_0000, map_q};
        pin_mux_pkg::PROTECT_OFS: rd_data_q <= {31'h0000_0000, prot_q};
        pin_mux_pkg::STATUS_OFS:
          rd_data_q <= {23'h00_0000, blocked_q, 3'h0, rsvd};
        default:                  rd_data_q <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // routing of each pin; reserved selections release the pin rather
  // than drive it, the safest of the undefined behaviours allowed
  always_comb begin
    for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
      drive_d[i] = RELEASED;
      if (rsvd[i]) begin
        drive_d[i] = RELEASED; // [RL10] [RL11]
      end else begin
        case (field(sel_q, i))
          pin_mux_pkg::CODE_GPIO: drive_d[i] = gpio_drive[i];
          default: drive_d[i] = RELEASED;
        endcase
      end
    end
    // pin 4
    if (!rsvd[0] && field(sel_q, 0) == pin_mux_pkg::CODE_PWM) begin
      drive_d[0] = '{out: alt ? pwm5_channel_a : pwm3_channel_a,
                     oe_n: 1'b0}; // [RL9]
    end
    // pin 5
    if (!rsvd[1]) begin
      case (field(sel_q, 1))
        pin_mux_pkg::CODE_PWM:
          drive_d[1] = '{out: alt ? pwm6_channel_a : pwm3_channel_b,
                         oe_n: 1'b0}; // [RL8]
        pin_mux_pkg::CODE_FN2: drive_d[1] = spi_d_clock; // [RL7]
        pin_mux_pkg::CODE_FN3: drive_d[1] = capture_unit_1_signal; // [RL7]
        default: ;
      endcase
    end
    // pin 6; sync input leaves the pin released
    if (!rsvd[2]) begin
      case (field(sel_q, 2))
        pin_mux_pkg::CODE_PWM:
          drive_d[2] = '{out: alt ? pwm7_channel_a : pwm4_channel_a,
                         oe_n: 1'b0}; // [RL6]
        pin_mux_pkg::CODE_FN2: drive_d[2] = RELEASED; // [RL5]
        pin_mux_pkg::CODE_FN3:
          drive_d[2] = '{out: pwm_sync_output, oe_n: 1'b0}; // [RL5]
        default: ;
      endcase
    end
    // pin 7
    if (!rsvd[3]) begin
      case (field(sel_q, 3))
        pin_mux_pkg::CODE_PWM:
          drive_d[3] = '{out: alt ? pwm8_channel_a : pwm4_channel_b,
                         oe_n: 1'b0}; // [RL4]
        pin_mux_pkg::CODE_FN2: drive_d[3] = spi_d_transmit_enable; // [RL3]
        pin_mux_pkg::CODE_FN3: drive_d[3] = capture_unit_2_signal; // [RL3]
        default: ;
      endcase
    end
    // pin 8
    if (!rsvd[4]) begin
      case (field(sel_q, 4))
        pin_mux_pkg::CODE_PWM:
          drive_d[4] = '{out: alt ? pwm9_channel_a : pwm5_channel_a,
                         oe_n: 1'b0}; // [RL2]
        pin_mux_pkg::CODE_FN2:
          drive_d[4] = '{out: can_b_transmit, oe_n: 1'b0}; // [RL1]
        pin_mux_pkg::CODE_FN3:
          drive_d[4] = '{out: adc_conversion_start_a_out,
                         oe_n: 1'b0}; // [RL1]
        default: ;
      endcase
    end
  end

  // pin drivers registered so every output leaves a flip-flop; each pin
  // only looks at its own field, so one write never disturbs another
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out_q  <= 5'h00;
      pin_oe_n_q <= 5'h1f;
    end else begin
      for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
        pin_out_q[i]  <= drive_d[i].out; // [RL13]
        pin_oe_n_q[i] <= drive_d[i].oe_n;
      end
    end
  end

  // inputs returned to peripherals; idle low when not selected, except gpio_in, which always follows the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_in_q    <= 5'h00;
      sync_in_q    <= 1'b0;
      spi_te_in_q  <= 1'b0;
      spi_clk_in_q <= 1'b0;
      cap1_in_q    <= 1'b0;
      cap2_in_q    <= 1'b0;
    end else begin
      gpio_in_q    <= pin_in;
      sync_in_q    <= !rsvd[2] && field(sel_q, 2) == pin_mux_pkg::CODE_FN2
                      && pin_in[2]; // [RL5]
      spi_clk_in_q <= !rsvd[1] && field(sel_q, 1) == pin_mux_pkg::CODE_FN2
                      && pin_in[1]; // [RL7]
      cap1_in_q    <= !rsvd[1] && field(sel_q, 1) == pin_mux_pkg::CODE_FN3
                      && pin_in[1];
      spi_te_in_q  <= !rsvd[3] && field(sel_q, 3) == pin_mux_pkg::CODE_FN2
                      && pin_in[3]; // [RL3]
      cap2_in_q    <= !rsvd[3] && field(sel_q, 3) == pin_mux_pkg::CODE_FN3
                      && pin_in[3];
    end
  end

  assign rd_data                  = rd_data_q;
  assign pin_out                  = pin_out_q;
  assign pin_oe_n                 = pin_oe_n_q;
  assign gpio_in                  = gpio_in_q;
  assign pwm_sync_input           = sync_in_q;
  assign spi_d_transmit_enable_in = spi_te_in_q;
  assign spi_d_clock_in           = spi_clk_in_q;
  assign capture_unit_1_in        = cap1_in_q;
  assign capture_unit_2_in        = cap2_in_q;

  // fields come out of reset at the gpio code
  a_reset_gpio: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> sel_q[17:8] == 10'h000 && pin_oe_n == 5'h1f) // [RL1]
    else $error("select fields not gpio after reset");

  a_pin8_can: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[17:16] == 2'h2 && HAS_CAN_B != 0)
      |=> pin_out[4] == $past(can_b_transmit) && !pin_oe_n[4]) // [RL1]
    else $error("pin 8 not driven by can-b transmit");

  a_pin8_adc: assert property (@(posedge clk) disable iff (!rst_n)
    sel_q[17:16] == 2'h3
      |=> pin_out[4] == $past(adc_conversion_start_a_out)) // [RL1]
    else $error("pin 8 not driven by adc start");

  a_pin8_pwm_map: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[17:16] == 2'h1 && !rsvd[4])
      |=> pin_out[4] == ($past(alt) ? $past(pwm9_channel_a)
                                    : $past(pwm5_channel_a))) // [RL2]
    else $error("pin 8 pwm mapping wrong");

  a_pin7_spi_te: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[15:14] == 2'h2 && HAS_SPI_D != 0)
      |=> pin_oe_n[3] == $past(spi_d_transmit_enable.oe_n)) // [RL3]
    else $error("pin 7 enable not from spi-d");

  a_pin7_pwm_map: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[15:14] == 2'h1 && !rsvd[3])
      |=> pin_out[3] == ($past(alt) ? $past(pwm8_channel_a)
                                    : $past(pwm4_channel_b))) // [RL4]
    else $error("pin 7 pwm mapping wrong");

  a_pin6_sync: assert property (@(posedge clk) disable iff (!rst_n)
    sel_q[13:12] == 2'h2 ##1 sel_q[13:12] == 2'h2
      |-> pin_oe_n[2] && pwm_sync_input == $past(pin_in[2])) // [RL5]
    else $error("pin 6 sync input path wrong");

  a_pin6_pwm_map: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[13:12] == 2'h1 && !rsvd[2])
      |=> pin_out[2] == ($past(alt) ? $past(pwm7_channel_a)
                                    : $past(pwm4_channel_a))) // [RL6]
    else $error("pin 6 pwm mapping wrong");

  a_pin5_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[11:10] == 2'h3 && HAS_CAP1 != 0)
      |=> pin_out[1] == $past(capture_unit_1_signal.out)) // [RL7]
    else $error("pin 5 not driven by capture unit 1");

  a_pin5_pwm_map: assert property (@(posedge clk) disable iff (!rst_n)
    (sel_q[11:10] == 2'h1 && !rsvd[1])
      |=> pin_out[1] == ($past(alt) ? $past(pwm6_channel_a)
                                    : $past(pwm3_channel_b))) // [RL8]
    else $error("pin 5 pwm mapping wrong");

  a_pin4_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    sel_q[9] |-> rsvd[0] ##1 pin_oe_n[0]) // [RL9]
    else $error("pin 4 reserved code drives pin");

  a_absent_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    sel_q[17:16] == 2'h2 |-> rsvd[4] == (HAS_CAN_B == 0)) // [RL11]
    else $error("can-b code reservation wrong for variant");

  a_reserved_release: assert property (@(posedge clk) disable iff (!rst_n)
    rsvd[0] |=> pin_oe_n[0] && !pin_out[0]) // [RL10]
    else $error("reserved pin 4 code not released");

  a_protect_block: assert property (@(posedge clk) disable iff (!rst_n)
    sel_wr && !prot_q |=> $stable(sel_q) && blocked_q) // [RL12]
    else $error("select changed without protected write enable");

  a_route_next: assert property (@(posedge clk) disable iff (!rst_n)
    sel_wr && prot_q && req.wdata[17:16] == 2'h3
      |=> sel_q[17:16] == 2'h3 ##1
          pin_out[4] == $past(adc_conversion_start_a_out)) // [RL13]
    else $error("new selection not routed in time");

endmodule

/* tb/periph_model.sv */
`timescale 1ns/10ps

// stands in for the peripherals and the board around the pins
module periph_model (
  input  wire logic                 clk,
  input  wire logic [4:0]           pin_out,
  input  wire logic [4:0]           pin_oe_n,
  output logic [4:0]                pin_in,
  output pin_mux_pkg::drive_t [4:0] gpio_drive,
  output logic [8:0]                pwm,
  output logic [2:0]                misc,
  output pin_mux_pkg::drive_t [3:0] bidir
);
  logic [31:0] cnt_q = 32'h1234_5678;

  // pattern source; it changes every cycle so a stale route never matches
  always @(posedge clk) begin
    cnt_q <= cnt_q * 32'h0001_9665 + 32'h3c6e_f35f;
  end

  // pwm order: 3a 3b 4a 4b 5a 6a 7a 8a 9a; misc: can-b, adc start, sync out
  assign pwm        = cnt_q[8:0];
  assign misc       = cnt_q[11:9];
  assign bidir      = cnt_q[19:12];
  assign gpio_drive = cnt_q[29:20];
  // no pull on the pins: a released pin wanders rather than holding a level
  assign pin_in = (pin_out & ~pin_oe_n) | (cnt_q[31:27] & pin_oe_n);
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps

module tb;
  logic                      clk = 1'h0;
  logic                      rst_n = 1'h0;
  pin_mux_pkg::reg_req_t     req = '0;
  logic [31:0]               rd_data;
  logic [4:0]                pin_in, pin_out, pin_oe_n, gpio_in, lite_oe_n;
  wire logic [4:0]           back;
  pin_mux_pkg::drive_t [4:0] gpio_drive;
  pin_mux_pkg::drive_t [3:0] bidir;
  logic [8:0]                pwm;
  logic [2:0]                misc;
  logic [31:0]               sel_sh;
  logic [1:0]                map_sh;
  logic                      prot_sh;
  logic [4:0]                exp_out, exp_oe, exp_back, exp_gin, ro, roe;
  int                        miscompares = 0;
  int                        cmp_count = 0;
  typedef struct {
    logic [31:0] sel;
    logic [1:0]  map;
    logic [4:0]  flags;
  } row_t;
  // select value, map value, expected reserved flags in status
  row_t rows [8] = '{
    '{32'h0000_0000, 2'h0, 5'h00}, '{32'h0001_5500, 2'h0, 5'h00},
    '{32'h0001_5500, 2'h3, 5'h00}, '{32'h0001_5500, 2'h1, 5'h00},
    '{32'h0002_aa00, 2'h0, 5'h01}, '{32'h0003_ff00, 2'h3, 5'h01},
    '{32'h0002_d100, 2'h3, 5'h00}, '{32'h0003_bc00, 2'h0, 5'h00}};

  // clock
  always #20 clk = ~clk;

  periph_model far (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in), .gpio_drive(gpio_drive), .pwm(pwm), .misc(misc),
    .bidir(bidir));

  port_a_pin_function_mux dut (.clk(clk), .rst_n(rst_n), .req(req),
    .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .gpio_drive(gpio_drive), .gpio_in(gpio_in),
    .pwm3_channel_a(pwm[0]), .pwm3_channel_b(pwm[1]),
    .pwm4_channel_a(pwm[2]), .pwm4_channel_b(pwm[3]),
    .pwm5_channel_a(pwm[4]), .pwm6_channel_a(pwm[5]),
    .pwm7_channel_a(pwm[6]), .pwm8_channel_a(pwm[7]),
    .pwm9_channel_a(pwm[8]), .can_b_transmit(misc[0]),
    .adc_conversion_start_a_out(misc[1]), .pwm_sync_output(misc[2]),
    .spi_d_transmit_enable(bidir[0]), .spi_d_clock(bidir[1]),
    .capture_unit_1_signal(bidir[2]), .capture_unit_2_signal(bidir[3]),
    .pwm_sync_input(back[4]), .spi_d_transmit_enable_in(back[3]),
    .spi_d_clock_in(back[2]), .capture_unit_1_in(back[1]),
    .capture_unit_2_in(back[0]));

  // variant without can-b: its pin 8 code 10 must act as reserved
  port_a_pin_function_mux #(.HAS_CAN_B(0)) dut_lite (.clk(clk),
    .rst_n(rst_n), .req(req), .rd_data(), .pin_in(pin_in), .pin_out(),
    .pin_oe_n(lite_oe_n), .gpio_drive(gpio_drive), .gpio_in(),
    .pwm3_channel_a(pwm[0]), .pwm3_channel_b(pwm[1]),
    .pwm4_channel_a(pwm[2]), .pwm4_channel_b(pwm[3]),
    .pwm5_channel_a(pwm[4]), .pwm6_channel_a(pwm[5]),
    .pwm7_channel_a(pwm[6]), .pwm8_channel_a(pwm[7]),
    .pwm9_channel_a(pwm[8]), .can_b_transmit(misc[0]),
    .adc_conversion_start_a_out(misc[1]), .pwm_sync_output(misc[2]),
    .spi_d_transmit_enable(bidir[0]), .spi_d_clock(bidir[1]),
    .capture_unit_1_signal(bidir[2]), .capture_unit_2_signal(bidir[3]),
    .pwm_sync_input(), .spi_d_transmit_enable_in(), .spi_d_clock_in(),
    .capture_unit_1_in(), .capture_unit_2_in());

  // expected drive of pin 4+i for code c; reserved codes release the pin
  function automatic pin_mux_pkg::drive_t route(int i, logic [1:0] c,
                                                logic alt);
    pin_mux_pkg::drive_t d;
    d = '{out: 1'h0, oe_n: 1'h1};
    case (c)
      2'h0: d = gpio_drive[i];
      2'h1: d = '{out: pwm[alt ? i + 4 : i], oe_n: 1'h0};
      2'h2: begin
        if (i == 1) d = bidir[1];
        else if (i == 3) d = bidir[0];
        else if (i == 4) d = '{out: misc[0], oe_n: 1'h0};
      end
      default: begin
        if (i == 1) d = bidir[2];
        else if (i == 2) d = '{out: misc[2], oe_n: 1'h0};
        else if (i == 3) d = bidir[3];
        else if (i == 4) d = '{out: misc[1], oe_n: 1'h0};
      end
    endcase
    return d;
  endfunction

  // reference: register shadow, then pins one cycle behind the shadow
  always @(posedge clk) begin
    if (!rst_n) begin
      sel_sh <= pin_mux_pkg::SELECT_RESET;
      map_sh <= pin_mux_pkg::MAP_RESET;
      prot_sh <= pin_mux_pkg::PROT_RESET;
    end else if (req.wr) begin
      if (req.addr == pin_mux_pkg::PROTECT_OFS) prot_sh <= req.wdata[0];
      if (prot_sh && req.addr == pin_mux_pkg::SELECT_OFS)
        sel_sh <= req.wdata & pin_mux_pkg::SELECT_MASK;
      if (prot_sh && req.addr == pin_mux_pkg::MAP_OFS)
        map_sh <= req.wdata[1:0];
    end
    for (int i = 0; i < 5; i++)
      {ro[i], roe[i]} = route(i, sel_sh[8+2*i +: 2],
                              map_sh == pin_mux_pkg::MAP_ALT);
    exp_out <= ro;
    exp_oe <= roe;
    exp_back <= {sel_sh[13:12] == 2'h2 && pin_in[2],
                 sel_sh[15:14] == 2'h2 && pin_in[3],
                 sel_sh[11:10] == 2'h2 && pin_in[1],
                 sel_sh[11:10] == 2'h3 && pin_in[1],
                 sel_sh[15:14] == 2'h3 && pin_in[3]};
    exp_gin <= pin_in;
  end

  task automatic check(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    req.wr <= 1'h0;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic rd_reg(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    req.rd <= 1'h0;
    #1 check(rd_data, e);
  endtask

  // masked out bits: a released pin's data is not defined
  task automatic check_pins();
    @(posedge clk);
    #1 check({27'h0, pin_oe_n}, {27'h0, exp_oe});
    check({27'h0, pin_out & ~exp_oe}, {27'h0, exp_out & ~exp_oe});
    check({27'h0, back}, {27'h0, exp_back});
    check({27'h0, gpio_in}, {27'h0, exp_gin});
    check({31'h0, lite_oe_n[4]},
          {31'h0, exp_oe[4] | (sel_sh[17:16] == 2'h2)});
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 check({27'h0, pin_oe_n}, 32'h0000_001f);
    check(rd_data, 32'h0000_0000);
    @(posedge clk) rst_n <= 1'h1;
    rd_reg(pin_mux_pkg::SELECT_OFS, 32'h0000_0000);
    rd_reg(pin_mux_pkg::MAP_OFS, 32'h0000_0000);
    rd_reg(pin_mux_pkg::PROTECT_OFS, 32'h0000_0000);
    rd_reg(pin_mux_pkg::STATUS_OFS, 32'h0000_0000);
    wr_reg(pin_mux_pkg::PROTECT_OFS, 32'h0000_0001);
    rd_reg(pin_mux_pkg::PROTECT_OFS, 32'h0000_0001);
    foreach (rows[k]) begin
      wr_reg(pin_mux_pkg::MAP_OFS, {30'h0, rows[k].map});
      wr_reg(pin_mux_pkg::SELECT_OFS, rows[k].sel);
      repeat (3) check_pins();
      rd_reg(pin_mux_pkg::SELECT_OFS, rows[k].sel);
      rd_reg(pin_mux_pkg::STATUS_OFS, {27'h0, rows[k].flags});
      $display("row %0d done", k);
    end
    // refused writes while protection is off, sticky flag, clear
    wr_reg(pin_mux_pkg::PROTECT_OFS, 32'h0000_0000);
    wr_reg(pin_mux_pkg::SELECT_OFS, 32'h0001_5500);
    wr_reg(pin_mux_pkg::MAP_OFS, 32'h0000_0003);
    check_pins();
    rd_reg(pin_mux_pkg::SELECT_OFS, 32'h0003_bc00);
    rd_reg(pin_mux_pkg::MAP_OFS, 32'h0000_0000);
    rd_reg(pin_mux_pkg::STATUS_OFS, 32'h0000_0100);
    wr_reg(pin_mux_pkg::STATUS_OFS, 32'h0000_0100);
    rd_reg(pin_mux_pkg::STATUS_OFS, 32'h0000_0000);
    $display("protection test done");
    // unimplemented bits and unmapped address read zero
    wr_reg(pin_mux_pkg::PROTECT_OFS, 32'h0000_0001);
    wr_reg(pin_mux_pkg::SELECT_OFS, 32'hffff_ffff);
    rd_reg(pin_mux_pkg::SELECT_OFS, 32'h0003_ff00);
    @(posedge clk);
    #1 check(rd_data, 32'h0000_0000);
    wr_reg(8'h10, 32'hffff_ffff);
    rd_reg(8'h10, 32'h0000_0000);
    $display("decode test done");
    // reset in mid-run returns every pin to gpio and protection off
    @(posedge clk) rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1 check({27'h0, pin_oe_n}, 32'h0000_001f);
    @(posedge clk) rst_n <= 1'h1;
    rd_reg(pin_mux_pkg::SELECT_OFS, 32'h0000_0000);
    rd_reg(pin_mux_pkg::PROTECT_OFS, 32'h0000_0000);
    check_pins();
    $display("reset test done");
    end_sim();
  end
endmodule
